// File: hw/pum_pkg.sv
// Shared constants, types and helpers of the transmit utilization monitor.
// Assumes a single 10 MHz clock shared by the monitor and the tapped stream.
package pum_pkg;

  localparam int unsigned DATA_W = 64;
  localparam int unsigned KEEP_W = 8;
  localparam int unsigned CNT_W = 32;
  localparam int unsigned TAG_W = 2;
  localparam int unsigned LANE_CNT_W = 4;

  // Sampling window timing
  localparam int unsigned CLK_FREQ_HZ = 10_000_000;
  localparam int unsigned WINDOW_S = 1;
  localparam int unsigned WINDOW_CYCLES = WINDOW_S * CLK_FREQ_HZ;
  localparam int unsigned TIMER_W = 32;

  // Reset values
  localparam logic [CNT_W-1:0] COUNT_RESET = 32'h0;
  localparam logic [TAG_W-1:0] TAG_RESET = 2'h0;
  localparam logic [TIMER_W-1:0] TIMER_RESET = 32'h0;

  // Header word 0 field positions (first header dword in data bits 31:0)
  localparam int unsigned HDR_FMT_DATA_BIT = 30;
  localparam int unsigned HDR_TYPE_LSB = 24;
  localparam int unsigned HDR_TYPE_W = 5;
  localparam logic [HDR_TYPE_W-1:0] TYPE_MEM = 5'h00;
  localparam logic [HDR_TYPE_W-1:0] TYPE_CPL = 5'h0a;

  // Count of the low report bits replaced by the window tag
  localparam int unsigned REPORT_LSB = TAG_W;

  typedef struct packed {
    logic [DATA_W-1:0] tdata;
    logic [KEEP_W-1:0] tkeep;
    logic tlast;
    logic tvalid;
    logic tready;
  } pum_tx_tap_t;

  function automatic logic [LANE_CNT_W-1:0] pum_lane_count(input logic [KEEP_W-1:0] keep);
    logic [LANE_CNT_W-1:0] n;
    n = '0;
    for (int i = 0; i < KEEP_W; i++) begin
      n = n + LANE_CNT_W'(keep[i]);
    end
    return n;
  endfunction : pum_lane_count

endpackage : pum_pkg

// File: hw/pum_beat_decode.sv
// Per-beat decode of the tapped transmit stream: handshake, byte count, class.
// Assumes the tap signals are synchronous to the monitor clock.
module pum_beat_decode
  import pum_pkg::*;
(
  input wire pum_tx_tap_t tap_i,
  output logic beat_o,
  output logic [LANE_CNT_W-1:0] bytes_o,
  output logic hdr_payload_o
);

  logic [HDR_TYPE_W-1:0] hdr_type;

  assign beat_o = tap_i.tvalid & tap_i.tready;

  assign bytes_o = beat_o ? pum_lane_count(tap_i.tkeep) : '0;

  assign hdr_type = tap_i.tdata[HDR_TYPE_LSB +: HDR_TYPE_W];
  assign hdr_payload_o = tap_i.tdata[HDR_FMT_DATA_BIT]
                         & ((hdr_type == TYPE_MEM) | (hdr_type == TYPE_CPL));

endmodule : pum_beat_decode

// File: hw/pum_tx_monitor.sv
// Passive transmit utilization monitor: raw and payload byte counts per window.
// Assumes the tap is wired in parallel to the stream; nothing here drives it.
module pum_tx_monitor
  import pum_pkg::*;
#(
  parameter int unsigned WINDOW_CYCLES_P = WINDOW_CYCLES
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire pum_tx_tap_t tx_tap_i,
  output logic [CNT_W-1:0] tx_byte_count_o,
  output logic [CNT_W-1:0] tx_payload_count_o,
  output logic [TAG_W-1:0] window_tag_o,
  output logic window_tick_o
);

  localparam logic [TIMER_W-1:0] TIMER_LAST = TIMER_W'(WINDOW_CYCLES_P - 1);

  logic beat;
  logic [LANE_CNT_W-1:0] beat_bytes;
  logic hdr_payload;
  logic mid_pkt_q;
  logic pay_pkt_q;
  logic beat_payload;
  logic expire;
  logic [TIMER_W-1:0] timer_q;
  logic [CNT_W-1:0] byte_acc_q;
  logic [CNT_W-1:0] pay_acc_q;
  logic [CNT_W-1:0] byte_inc;
  logic [CNT_W-1:0] pay_inc;
  logic [CNT_W-1:0] byte_sum;
  logic [CNT_W-1:0] pay_sum;
  logic [TAG_W-1:0] tag_q;
  logic [TAG_W-1:0] tag_next;

  pum_beat_decode u_decode (
    .tap_i(tx_tap_i),
    .beat_o(beat),
    .bytes_o(beat_bytes),
    .hdr_payload_o(hdr_payload)
  );

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      mid_pkt_q <= 1'b0;
      pay_pkt_q <= 1'b0;
    end else if (beat) begin
      mid_pkt_q <= ~tx_tap_i.tlast;
      if (!mid_pkt_q) begin
        pay_pkt_q <= hdr_payload;
      end
    end
  end

  assign beat_payload = mid_pkt_q ? pay_pkt_q : hdr_payload;

  assign expire = (timer_q == TIMER_LAST);

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      timer_q <= TIMER_RESET;
    end else if (expire) begin
      timer_q <= TIMER_RESET;
    end else begin
      timer_q <= timer_q + TIMER_W'(1);
    end
  end

  assign byte_inc = CNT_W'(beat_bytes);
  assign pay_inc = beat_payload ? CNT_W'(beat_bytes) : COUNT_RESET;
  assign byte_sum = byte_acc_q + byte_inc;
  assign pay_sum = pay_acc_q + pay_inc;

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      byte_acc_q <= COUNT_RESET;
      pay_acc_q <= COUNT_RESET;
    end else if (expire) begin
      byte_acc_q <= COUNT_RESET;
      pay_acc_q <= COUNT_RESET;
    end else begin
      byte_acc_q <= byte_sum;
      pay_acc_q <= pay_sum;
    end
  end

  assign tag_next = tag_q + TAG_W'(1);

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      tag_q <= TAG_RESET;
    end else if (expire) begin
      tag_q <= tag_next;
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      tx_byte_count_o <= COUNT_RESET;
      tx_payload_count_o <= COUNT_RESET;
      window_tag_o <= TAG_RESET;
      window_tick_o <= 1'b0;
    end else begin
      window_tick_o <= expire;
      if (expire) begin
        tx_byte_count_o <= {byte_sum[CNT_W-1:REPORT_LSB], tag_next};
        tx_payload_count_o <= {pay_sum[CNT_W-1:REPORT_LSB], tag_next};
        window_tag_o <= tag_next;
      end
    end
  end

  default clocking cb @(posedge clock_i);
  endclocking

  default disable iff (reset_i);

  sequence s_window_end;
    expire ##1 (timer_q == TIMER_RESET);
  endsequence

  sequence s_window_run;
    !expire ##1 (timer_q == $past(timer_q) + TIMER_W'(1));
  endsequence

  property p_timer_wrap;
    expire |-> s_window_end;
  endproperty
  a_timer_wrap: assert property (p_timer_wrap) else $error("timer did not restart");

  property p_timer_step;
    !expire |-> s_window_run;
  endproperty
  a_timer_step: assert property (p_timer_step) else $error("timer did not advance");

  property p_raw_add;
    !expire |=> byte_acc_q == $past(byte_acc_q) + CNT_W'($past(beat_bytes));
  endproperty
  a_raw_add: assert property (p_raw_add) else $error("raw count missed a beat");

  property p_no_beat_hold;
    (!expire && !(tx_tap_i.tvalid && tx_tap_i.tready)) |=> $stable(byte_acc_q);
  endproperty
  a_no_beat_hold: assert property (p_no_beat_hold) else $error("count without handshake");

  property p_pay_skip;
    (!expire && !beat_payload) |=> $stable(pay_acc_q);
  endproperty
  a_pay_skip: assert property (p_pay_skip) else $error("payload counted other traffic");

  property p_tag_step;
    expire |=> (window_tag_o == $past(tag_q) + TAG_W'(1)) && window_tick_o;
  endproperty
  a_tag_step: assert property (p_tag_step) else $error("window tag did not advance");

  property p_tag_in_report;
    window_tick_o |-> (tx_byte_count_o[TAG_W-1:0] == window_tag_o)
                      && (tx_payload_count_o[TAG_W-1:0] == window_tag_o);
  endproperty
  a_tag_in_report: assert property (p_tag_in_report) else $error("report low bits not tag");

  property p_load;
    expire |=> tx_byte_count_o[CNT_W-1:REPORT_LSB] == $past(byte_sum[CNT_W-1:REPORT_LSB]);
  endproperty
  a_load: assert property (p_load) else $error("report not loaded at expiry");

  property p_hold;
    !expire |=> $stable(tx_byte_count_o) && $stable(tx_payload_count_o) && !window_tick_o;
  endproperty
  a_hold: assert property (p_hold) else $error("report changed mid window");

  property p_restart;
    expire |=> byte_acc_q == COUNT_RESET;
  endproperty
  a_restart: assert property (p_restart) else $error("accumulator did not restart");

  property p_pay_restart;
    expire |=> pay_acc_q == COUNT_RESET;
  endproperty
  a_pay_restart: assert property (p_pay_restart) else $error("payload did not restart");

  property p_pay_load;
    expire |=> tx_payload_count_o[CNT_W-1:REPORT_LSB] == $past(pay_sum[CNT_W-1:REPORT_LSB]);
  endproperty
  a_pay_load: assert property (p_pay_load) else $error("payload report not loaded");

  property p_pay_add;
    (!expire && beat_payload)
      |=> pay_acc_q == $past(pay_acc_q) + CNT_W'($past(beat_bytes));
  endproperty
  a_pay_add: assert property (p_pay_add) else $error("payload count missed a beat");

  property p_tick_cause;
    window_tick_o |-> $past(expire);
  endproperty
  a_tick_cause: assert property (p_tick_cause) else $error("tick without expiry");

  property p_timer_bound;
    timer_q <= TIMER_LAST;
  endproperty
  a_timer_bound: assert property (p_timer_bound) else $error("timer past window end");

  property p_frame_track;
    beat |=> mid_pkt_q == !$past(tx_tap_i.tlast);
  endproperty
  a_frame_track: assert property (p_frame_track) else $error("packet framing lost");

  property p_frame_hold;
    !beat |=> $stable(mid_pkt_q) && $stable(pay_pkt_q);
  endproperty
  a_frame_hold: assert property (p_frame_hold) else $error("framing moved without beat");

endmodule : pum_tx_monitor

// File: verif/pum_tx_source.sv
// Stream source model standing in for the DMA engine.
// Assumes tready comes from the bench; drives at the falling edge.
module pum_tx_source
  import pum_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic ready_i,
  output pum_tx_tap_t tap_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int left = 0;
  logic took = 1'b0;
  logic [63:0] d;
  logic [4:0] tab [4] = '{TYPE_MEM, TYPE_CPL, 5'h04, 5'h05};
  always @(posedge clock_i) took = tap_o.tvalid && ready_i;
  always @(negedge clock_i) begin
    if (reset_i) begin
      left = 0;
      tap_o <= '0;
    end else if (!tap_o.tvalid || took) begin
      if ($urandom % 4 == 0) begin
        tap_o.tvalid <= 1'b0;
        tap_o.tlast <= ~tap_o.tlast;
        tap_o.tkeep <= 8'($urandom);
      end else begin
        d = {$urandom, $urandom};
        if (left == 0) begin
          left = 1 + $urandom % 4;
          d[31:0] = {1'b0, 1'($urandom), 1'b0, tab[$urandom % 4], 24'($urandom)};
        end
        tap_o.tdata <= d;
        tap_o.tkeep <= (left > 1 || $urandom % 2) ? 8'hff : 8'h0f;
        tap_o.tlast <= (left == 1);
        tap_o.tvalid <= 1'b1;
        left = left - 1;
      end
    end
  end
endmodule : pum_tx_source

// File: verif/tb_pcie_stream_utilization_monitor.sv
// Self-checking bench of the transmit utilization monitor.
// Assumes a short window and the stream source model beside it.
module tb_pcie_stream_utilization_monitor
  import pum_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned N = 20;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic ready = 1'b0;
  pum_tx_tap_t src_tap, tap;
  logic [CNT_W-1:0] byte_cnt, pay_cnt, e_raw, e_pay;
  logic [TAG_W-1:0] tag, e_tag;
  logic tick, first, cls;
  logic [65:0] note, exp_q[$];
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int cyc = 0;
  always_comb begin
    tap = src_tap;
    tap.tready = ready;
  end
  initial forever #50 clock = ~clock;
  pum_tx_source pum_tx_source_i (.clock_i(clock), .reset_i(reset), .ready_i(ready),
    .tap_o(src_tap));
  pum_tx_monitor #(.WINDOW_CYCLES_P(N)) pum_tx_monitor_i (.clock_i(clock),
    .reset_i(reset), .tx_tap_i(tap), .tx_byte_count_o(byte_cnt),
    .tx_payload_count_o(pay_cnt), .window_tag_o(tag), .window_tick_o(tick));
  task automatic err(input string msg);
    num_errors++;
    $display("[ERR] %0t %s", $time, msg);
  endtask : err
  task automatic close_out;
    if (exp_q.size() != 0) err("report missing");
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out
  always @(posedge clock) begin
    if (reset) begin
      {e_raw, e_pay, e_tag, cyc, first} = '0;
      first = 1'b1;
      exp_q.delete();
    end else begin
      if (tap.tvalid && tap.tready) begin
        if (first) cls = tap.tdata[30] && (tap.tdata[28:24] inside {TYPE_MEM, TYPE_CPL});
        e_raw += CNT_W'($countones(tap.tkeep));
        if (cls) e_pay += CNT_W'($countones(tap.tkeep));
        first = tap.tlast;
      end
      cyc++;
      if (cyc == N) begin
        e_tag++;
        exp_q.push_back({e_raw[31:2], e_tag, e_pay[31:2], e_tag, e_tag});
        {e_raw, e_pay, cyc} = '0;
      end
    end
  end
  always @(negedge clock) begin
    cycles++;
    if (cycles > 1000) begin
      err("timeout");
      close_out();
    end else if (tick === 1'b1) begin
      if (exp_q.size() == 0) err("unexpected report");
      else begin
        note = exp_q.pop_front();
        total_checks += 3;
        if (byte_cnt !== note[65:34]) err("raw count");
        if (pay_cnt !== note[33:2]) err("payload count");
        if (tag !== note[1:0]) err("window tag");
      end
    end else if (tick !== 1'b0) err("tick unknown");
  end
  initial begin
    void'($urandom(32'h712c));
    repeat (10) @(negedge clock);
    reset = 1'b0;
    repeat (7 * N + N / 2) @(negedge clock) ready = 1'($urandom % 4 != 0);
    reset = 1'b1;
    @(negedge clock);
    total_checks += 3;
    if (byte_cnt !== '0) err("raw not cleared");
    if (pay_cnt !== '0) err("payload not cleared");
    if (tag !== '0) err("tag not cleared");
    @(negedge clock) reset = 1'b0;
    repeat (5 * N) @(negedge clock) ready = 1'b1;
    repeat (2 * N) @(negedge clock) ready = 1'b0;
    repeat (2) @(negedge clock);
    close_out();
  end
endmodule : tb_pcie_stream_utilization_monitor
